// File: inc/psb_pkg.sv
// Constants, types and helpers for the serial block protocol framer
package psb_pkg;
  // Control and framing characters
  localparam logic [7:0] C_SOH      = 8'h01;
  localparam logic [7:0] C_STX      = 8'h02;
  localparam logic [7:0] C_ETX      = 8'h03;
  localparam logic [7:0] C_EOT      = 8'h04;
  localparam logic [7:0] C_ENQ      = 8'h05;
  localparam logic [7:0] C_ACK      = 8'h06;
  localparam logic [7:0] C_NAK      = 8'h15;
  localparam logic [7:0] C_ETB      = 8'h17;
  localparam logic [7:0] C_NORMAL   = 8'h4e;
  localparam logic [7:0] C_QUICK    = 8'h51;
  localparam logic [7:0] C_ADDR_OFS = 8'h20;
  localparam logic [7:0] C_ADDR_MIN = 8'h21;
  localparam logic [7:0] C_ADDR_MAX = 8'h7a;
  localparam logic [7:0] C_ID_ALL   = 8'hff;
  // ASCII hex digits
  localparam logic [7:0] C_ASC_0    = 8'h30;
  localparam logic [7:0] C_ASC_9    = 8'h39;
  localparam logic [7:0] C_ASC_A    = 8'h41;
  localparam logic [7:0] C_ASC_F    = 8'h46;
  localparam logic [7:0] C_HEX_TEN  = 8'h0a;
  // Header layout, zero based byte index
  localparam logic [4:0] HDR_ETB_IDX = 5'h0f;
  localparam logic [4:0] HDR_LRC_IDX = 5'h10;
  localparam int unsigned HDR_SUM_LO = 1;
  localparam int unsigned HDR_SUM_HI = 14;
  // Blocks and memory types
  localparam logic [8:0] BLK_MAX      = 9'h100;
  localparam logic [3:0] QRSP_LEN     = 4'h8;
  localparam logic [6:0] MT_PLAIN_MAX = 7'h09;
  localparam logic [6:0] MT_BIT_MIN   = 7'h0d;
  localparam logic [6:0] MT_BIT_MAX   = 7'h16;
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MS_IN_NS       = 1000000;
  localparam int unsigned CYC_PER_MS     = MS_IN_NS / CLK_PERIOD_NS;
  localparam int unsigned T_CHAR_WAIT_MS = 800;
  localparam int unsigned T_BLK_WAIT_MS  = 20000;
  localparam int unsigned T_REPLY_MS     = 800;
  localparam int unsigned BO_300_ID0_MS  = 300;
  localparam int unsigned BO_300_ID1_MS  = 440;
  localparam int unsigned BO_600_ID0_MS  = 140;
  localparam int unsigned BO_600_ID1_MS  = 220;
  localparam int unsigned BO_HI_ID0_MS   = 80;
  localparam int unsigned BO_HI_ID1_MS   = 120;

  typedef enum logic [1:0] {RATE_300, RATE_600, RATE_HI} psb_rate_t;

  function automatic logic [4:0] psb_hex_nib(input logic [7:0] c);
    if (c >= C_ASC_0 && c <= C_ASC_9) return {1'b1, 4'(c - C_ASC_0)};
    if (c >= C_ASC_A && c <= C_ASC_F)
      return {1'b1, 4'(c - C_ASC_A + C_HEX_TEN)};
    return 5'h00;
  endfunction

  // Bit 8 flags two valid digits
  function automatic logic [8:0] psb_hex_byte(input logic [7:0] hi,
                                              input logic [7:0] lo);
    logic [4:0] h;
    logic [4:0] l;
    h = psb_hex_nib(hi);
    l = psb_hex_nib(lo);
    return {h[4] & l[4], h[3:0], l[3:0]};
  endfunction

  function automatic logic [15:0] psb_backoff_ms(input psb_rate_t rate,
                                                 input logic idb);
    unique case (rate)
      RATE_300: return idb ? 16'(BO_300_ID1_MS) : 16'(BO_300_ID0_MS);
      RATE_600: return idb ? 16'(BO_600_ID1_MS) : 16'(BO_600_ID0_MS);
      default:  return idb ? 16'(BO_HI_ID1_MS) : 16'(BO_HI_ID0_MS);
    endcase
  endfunction
endpackage

// File: inc/psb_tmr_if.sv
// Millisecond wait timer link between framer and timer
`timescale 1ns/10ps
`default_nettype none
interface psb_tmr_if;
  logic        start;
  logic [15:0] ms;
  logic        expired;
  modport ctl (output start, output ms, input expired);
  modport tmr (input start, input ms, output expired);
endinterface
`default_nettype wire

// File: hw/psb_timer.sv
// Restartable millisecond wait timer
`timescale 1ns/10ps
`default_nettype none
module psb_timer
  import psb_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  // Control
  psb_tmr_if.tmr    tm
);
  localparam int unsigned PW = (CYC_PER_MS_P > 2) ? $clog2(CYC_PER_MS_P) : 1;
  localparam logic [PW-1:0] PRE_END = PW'(CYC_PER_MS_P - 1);

  if (CYC_PER_MS_P < 2) begin : g_bad
    $error("CYC_PER_MS_P must be at least 2");
  end

  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic [15:0]   ms_r;
  logic [15:0]   ms_nxt;
  logic          run_r;
  logic          run_nxt;
  logic          exp_r;
  logic          exp_nxt;

  // A restart always wins, so stale expiry never leaks into a new wait
  always_comb begin
    pre_nxt = pre_r;
    ms_nxt  = ms_r;
    run_nxt = run_r;
    exp_nxt = exp_r;
    if (tm.start) begin
      pre_nxt = '0;
      ms_nxt  = tm.ms;
      run_nxt = 1'b1;
      exp_nxt = 1'b0;
    end else if (run_r) begin
      if (ms_r == 16'h0000) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else if (pre_r == PRE_END) begin
        pre_nxt = '0;
        ms_nxt  = ms_r - 16'h0001;
      end else begin
        pre_nxt = pre_r + PW'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_r <= '0;
      ms_r  <= 16'h0000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      ms_r  <= ms_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign tm.expired = exp_r;
endmodule
`default_nettype wire

// File: hw/psb_framer.sv
// Responder side framer and handshake engine for the serial block link
//
// What this block does
// - Header is 17 bytes: SOH first, ETB at 16, check byte at 17.
// - Header check byte is XOR of bytes 2 to 15, recomputed and compared.
// - Data blocks move only after header ACK, direction from the header.
// - Up to 256 bytes is one block; longer splits into full 256 blocks, then any remainder.
// - Block starts with STX, ends ETB or ETX on last, then check byte.
// - Block holds 1 to 256 characters; check byte is their XOR.
// - Sender of final block sends EOT after that block is acknowledged.
// - Master always ends each transaction with its own EOT; in peer mode this block ends a read at its own EOT, without waiting.
// - Any exchange that cannot complete is aborted by sending EOT.
// - Unanswered peer enquiry is a collision; back off listening, then retry.
// - Back-off set by own ID bit and line rate, 80 to 440 ms.
// - Address character is slave ID plus 20h, valid 21h to 7Ah.
// - Slave answers normal enquiry with N, address, then ACK or NAK.
// - Slave quick reply: Q, address, four data, their XOR, ACK.
// - Bit set, clear and toggle memory types accept writes only.
// - Numeric header fields travel as ASCII coded hex digits.
// - Header byte 4 gives direction, 30h read, 38h write.
// - A link timeout from header wait onward aborts the exchange and sends EOT.
// - No retransmission once EOT has been received.
`timescale 1ns/10ps
`default_nettype none
module psb_framer
  import psb_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // Station configuration
  input  wire logic        i_peer_mode,
  input  wire logic [7:0]  i_station_id,
  input  wire logic [1:0]  i_rate_sel,
  input  wire logic        i_refuse,
  input  wire logic        i_enq_req,
  input  wire logic [31:0] i_quick_data,
  // Character receiver
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  // Character transmitter
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  // Read data source
  input  wire logic [7:0]  i_rd_data,
  output logic             o_rd_take,
  // Write data sink
  output logic             o_wr_valid,
  output logic [7:0]       o_wr_data,
  // Transfer status
  output logic             o_hdr_valid,
  output logic             o_hdr_write,
  output logic [6:0]       o_hdr_mtype,
  output logic [15:0]      o_hdr_addr,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_abort,
  output logic             o_enq_grant
);
  typedef enum logic [4:0] {
    S_IDLE, S_ADDR, S_ENQ3, S_TX, S_SOH, S_HDR, S_STX, S_DATA, S_DTERM,
    S_DLRC, S_RD_STX, S_RD_DATA, S_RD_ACK, S_EOT, S_ENQ_WAIT, S_BACKOFF
  } psb_state_t;

  typedef struct packed {
    psb_state_t       st;
    psb_state_t       ret;
    logic [7:0][7:0]  qbuf;
    logic [3:0]       qlen;
    logic [3:0]       qidx;
    logic [16:0][7:0] hdr;
    logic [4:0]       hcnt;
    logic             is_q;
    logic             wr;
    logic [7:0]       blk_left;
    logic [7:0]       last_cnt;
    logic [8:0]       blen;
    logic [8:0]       bcnt;
    logic             last_blk;
    logic [7:0]       lrc;
    logic [2:0]       bo_idx;
    logic             tx_v;
    logic [7:0]       tx_d;
    logic             rd_take;
    logic             wr_v;
    logic [7:0]       wr_d;
    logic             hdr_v;
    logic [6:0]       mtype;
    logic [15:0]      addr;
    logic             busy;
    logic             done;
    logic             abort;
    logic             grant;
  } psb_regs_t;

  localparam psb_regs_t REGS_RST = '0;

  psb_regs_t r;
  psb_regs_t n;

  // Queue up to eight characters for the transmit walker
  function automatic psb_regs_t q_send(input psb_regs_t x,
                                       input logic [3:0] len,
                                       input psb_state_t ret);
    x.qlen = len;
    x.qidx = 4'h0;
    x.ret  = ret;
    x.st   = S_TX;
    return x;
  endfunction

  function automatic psb_regs_t q_abort(input psb_regs_t x);
    x.qbuf[0] = C_EOT;
    x         = q_send(x, 4'h1, S_IDLE);
    x.abort   = 1'b1;
    return x;
  endfunction

  function automatic psb_regs_t blk_start(input psb_regs_t x);
    if (x.blk_left != 8'h00) begin
      x.blen     = BLK_MAX;
      x.blk_left = x.blk_left - 8'h01;
      x.last_blk = (x.blk_left == 8'h00) && (x.last_cnt == 8'h00);
    end else begin
      x.blen     = {1'b0, x.last_cnt};
      x.last_blk = 1'b1;
    end
    x.bcnt = x.blen;
    x.lrc  = 8'h00;
    return x;
  endfunction

  // Header decode
  logic [7:0] my_addr;
  logic       addr_ok;
  logic [7:0] q_lrc;
  logic [7:0] h_lrc;
  logic [8:0] tid_h;
  logic [8:0] mt_h;
  logic [8:0] ah_h;
  logic [8:0] al_h;
  logic [8:0] nb_h;
  logic [8:0] nl_h;
  logic [8:0] sid_h;
  logic       id_ok;
  logic       mt_ok;
  logic       hdr_ok;

  assign my_addr = i_station_id + C_ADDR_OFS;
  assign addr_ok = my_addr >= C_ADDR_MIN && my_addr <= C_ADDR_MAX;
  assign q_lrc   = i_quick_data[31:24] ^ i_quick_data[23:16] ^
                   i_quick_data[15:8] ^ i_quick_data[7:0];

  always_comb begin
    h_lrc = 8'h00;
    for (int i = HDR_SUM_LO; i <= HDR_SUM_HI; i++) begin
      h_lrc = h_lrc ^ r.hdr[i];
    end
    tid_h = psb_hex_byte(r.hdr[1], r.hdr[2]);
    mt_h  = psb_hex_byte(r.hdr[3], r.hdr[4]);
    ah_h  = psb_hex_byte(r.hdr[5], r.hdr[6]);
    al_h  = psb_hex_byte(r.hdr[7], r.hdr[8]);
    nb_h  = psb_hex_byte(r.hdr[9], r.hdr[10]);
    nl_h  = psb_hex_byte(r.hdr[11], r.hdr[12]);
    sid_h = psb_hex_byte(r.hdr[13], r.hdr[14]);
    id_ok = tid_h[7:0] == i_station_id ||
            (i_peer_mode && tid_h[7:0] == C_ID_ALL);
    // Bit functions only exist in the write half of the type space
    mt_ok = mt_h[6:0] <= MT_PLAIN_MAX ||
            (mt_h[7] && mt_h[6:0] >= MT_BIT_MIN &&
             mt_h[6:0] <= MT_BIT_MAX);
    hdr_ok = tid_h[8] && mt_h[8] && ah_h[8] && al_h[8] && nb_h[8] &&
             nl_h[8] && sid_h[8] && id_ok && mt_ok &&
             (nb_h[7:0] != 8'h00 || nl_h[7:0] != 8'h00) &&
             r.hdr[HDR_ETB_IDX] == C_ETB && i_rx_data == h_lrc;
  end

  // Wait timer
  psb_tmr_if u_tif();

  psb_timer #(
    .CYC_PER_MS_P (CYC_PER_MS_P)
  ) u_tmr (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .tm        (u_tif)
  );

  // Line noise must not stretch a back-off, so it restarts on entry only
  assign u_tif.start = (n.st != r.st) ||
                       (i_rx_valid && r.st != S_BACKOFF);
  always_comb begin
    unique case (n.st)
      S_ENQ_WAIT: u_tif.ms = 16'(T_REPLY_MS);
      S_BACKOFF:  u_tif.ms = psb_backoff_ms(psb_rate_t'(i_rate_sel),
                                            i_station_id[n.bo_idx]);
      S_STX, S_DATA, S_DTERM, S_DLRC, S_RD_ACK:
                  u_tif.ms = 16'(T_BLK_WAIT_MS);
      default:    u_tif.ms = 16'(T_CHAR_WAIT_MS);
    endcase
  end

  logic rx_eot;
  logic tmo;
  assign rx_eot = i_rx_valid && i_rx_data == C_EOT;
  assign tmo    = u_tif.expired;

  always_comb begin
    n         = r;
    n.rd_take = 1'b0;
    n.wr_v    = 1'b0;
    n.hdr_v   = 1'b0;
    n.done    = 1'b0;
    n.abort   = 1'b0;
    n.grant   = 1'b0;
    if (r.tx_v && i_tx_ready) n.tx_v = 1'b0;
    unique case (r.st)
      S_IDLE: begin
        if (i_rx_valid) begin
          if (i_peer_mode) begin
            if (i_rx_data == C_ENQ) begin
              n.qbuf[0] = C_ACK;
              n = q_send(n, 4'h1, S_SOH);
            end
          end else if (i_rx_data == C_NORMAL || i_rx_data == C_QUICK) begin
            n.is_q = i_rx_data == C_QUICK;
            n.st   = S_ADDR;
          end
        end else if (i_peer_mode && i_enq_req) begin
          n.qbuf[0] = C_ENQ;
          n = q_send(n, 4'h1, S_ENQ_WAIT);
        end
      end
      S_ADDR: if (i_rx_valid) begin
        n.st = (i_rx_data == my_addr && addr_ok) ? S_ENQ3 : S_IDLE;
      end
      S_ENQ3: if (i_rx_valid) begin
        if (i_rx_data != C_ENQ) begin
          n.st = S_IDLE;
        end else if (r.is_q) begin
          n.qbuf[0] = C_QUICK;
          n.qbuf[1] = my_addr;
          n.qbuf[2] = i_quick_data[31:24];
          n.qbuf[3] = i_quick_data[23:16];
          n.qbuf[4] = i_quick_data[15:8];
          n.qbuf[5] = i_quick_data[7:0];
          n.qbuf[6] = q_lrc;
          n.qbuf[7] = C_ACK;
          n = q_send(n, QRSP_LEN, S_EOT);
        end else begin
          n.qbuf[0] = C_NORMAL;
          n.qbuf[1] = my_addr;
          n.qbuf[2] = i_refuse ? C_NAK : C_ACK;
          n = q_send(n, 4'h3, i_refuse ? S_IDLE : S_SOH);
        end
      end
      S_TX: if (!r.tx_v) begin
        if (r.qidx < r.qlen) begin
          n.tx_v = 1'b1;
          n.tx_d = r.qbuf[r.qidx[2:0]];
          n.qidx = r.qidx + 4'h1;
        end else begin
          n.st = r.ret;
        end
      end
      S_SOH: begin
        if (rx_eot) begin
          n.st    = S_IDLE;
          n.abort = 1'b1;
        end else if (i_rx_valid && i_rx_data == C_SOH) begin
          n.hdr[0] = i_rx_data;
          n.hcnt   = 5'h01;
          n.st     = S_HDR;
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_HDR: begin
        if (i_rx_valid) begin
          n.hdr[r.hcnt] = i_rx_data;
          n.hcnt        = r.hcnt + 5'h01;
          if (r.hcnt == HDR_LRC_IDX) begin
            if (hdr_ok) begin
              n.hdr_v    = 1'b1;
              n.wr       = mt_h[7];
              n.mtype    = mt_h[6:0];
              n.addr     = {ah_h[7:0], al_h[7:0]};
              n.blk_left = nb_h[7:0];
              n.last_cnt = nl_h[7:0];
              n = blk_start(n);
              n.qbuf[0] = C_ACK;
              n = q_send(n, 4'h1, mt_h[7] ? S_STX : S_RD_STX);
            end else begin
              n.qbuf[0] = C_NAK;
              n = q_send(n, 4'h1, S_SOH);
            end
          end
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_STX: begin
        if (rx_eot) begin
          n.st    = S_IDLE;
          n.abort = 1'b1;
        end else if (i_rx_valid && i_rx_data == C_STX) begin
          n.st = S_DATA;
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_DATA: begin
        if (i_rx_valid) begin
          n.wr_v = 1'b1;
          n.wr_d = i_rx_data;
          n.lrc  = r.lrc ^ i_rx_data;
          n.bcnt = r.bcnt - 9'h001;
          if (r.bcnt == 9'h001) n.st = S_DTERM;
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_DTERM: begin
        if (i_rx_valid) begin
          if (i_rx_data == (r.last_blk ? C_ETX : C_ETB)) n.st = S_DLRC;
          else n = q_abort(n);
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_DLRC: begin
        if (i_rx_valid) begin
          if (i_rx_data == r.lrc) begin
            if (!r.last_blk) n = blk_start(n);
            n.qbuf[0] = C_ACK;
            n = q_send(n, 4'h1, r.last_blk ? S_EOT : S_STX);
          end else begin
            // Rejected bytes already left on the sink; retry rewrites them
            n.bcnt    = r.blen;
            n.lrc     = 8'h00;
            n.qbuf[0] = C_NAK;
            n = q_send(n, 4'h1, S_STX);
          end
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_RD_STX: begin
        n.qbuf[0] = C_STX;
        n = q_send(n, 4'h1, S_RD_DATA);
      end
      S_RD_DATA: if (!r.tx_v) begin
        if (r.bcnt != 9'h000) begin
          n.tx_v    = 1'b1;
          n.tx_d    = i_rd_data;
          n.rd_take = 1'b1;
          n.lrc     = r.lrc ^ i_rd_data;
          n.bcnt    = r.bcnt - 9'h001;
        end else begin
          n.qbuf[0] = r.last_blk ? C_ETX : C_ETB;
          n.qbuf[1] = r.lrc;
          n = q_send(n, 4'h2, S_RD_ACK);
        end
      end
      S_RD_ACK: begin
        if (rx_eot) begin
          n.st    = S_IDLE;
          n.abort = 1'b1;
        end else if (i_rx_valid && i_rx_data == C_ACK) begin
          if (r.last_blk) begin
            n.qbuf[0] = C_EOT;
            n.done    = i_peer_mode;
            n = q_send(n, 4'h1, i_peer_mode ? S_IDLE : S_EOT);
          end else begin
            n    = blk_start(n);
            n.st = S_RD_STX;
          end
        end else if (i_rx_valid || tmo) begin
          // The source is consumed, so a refused block cannot be resent
          n = q_abort(n);
        end
      end
      S_EOT: begin
        if (rx_eot) begin
          n.st   = S_IDLE;
          n.done = 1'b1;
        end else if (tmo) begin
          n = q_abort(n);
        end
      end
      S_ENQ_WAIT: begin
        if (i_rx_valid && i_rx_data == C_ACK) begin
          n.grant = 1'b1;
          n.st    = S_IDLE;
        end else if (i_rx_valid || tmo) begin
          n.bo_idx = r.bo_idx + 3'h1;
          n.st     = S_BACKOFF;
        end
      end
      S_BACKOFF: begin
        if (i_rx_valid && i_rx_data == C_ENQ) begin
          n.qbuf[0] = C_ACK;
          n = q_send(n, 4'h1, S_SOH);
        end else if (tmo) begin
          n.qbuf[0] = C_ENQ;
          n = q_send(n, 4'h1, S_ENQ_WAIT);
        end
      end
      default: n.st = S_IDLE;
    endcase
    n.busy = n.st != S_IDLE;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) r <= REGS_RST;
    else r <= n;
  end

  assign o_tx_valid  = r.tx_v;
  assign o_tx_data   = r.tx_d;
  assign o_rd_take   = r.rd_take;
  assign o_wr_valid  = r.wr_v;
  assign o_wr_data   = r.wr_d;
  assign o_hdr_valid = r.hdr_v;
  assign o_hdr_write = r.wr;
  assign o_hdr_mtype = r.mtype;
  assign o_hdr_addr  = r.addr;
  assign o_busy      = r.busy;
  assign o_done      = r.done;
  assign o_abort     = r.abort;
  assign o_enq_grant = r.grant;
endmodule
`default_nettype wire

// File: verification/psb_framer_asserts.sv
// Port checker for the serial block framer
`timescale 1ns/10ps
`default_nettype none
module psb_framer_asserts
  import psb_pkg::*;
(
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  // Inputs
  input wire logic        i_peer_mode,
  input wire logic        i_rx_valid,
  input wire logic        i_tx_ready,
  input wire logic [7:0]  i_rd_data,
  // Outputs
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        o_rd_take,
  input wire logic        o_wr_valid,
  input wire logic        o_hdr_valid,
  input wire logic        o_hdr_write,
  input wire logic [6:0]  o_hdr_mtype,
  input wire logic        o_done,
  input wire logic        o_abort,
  input wire logic        o_enq_grant
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  tx_hold_a: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx char moved before accept");
  tx_gap_a: assert property (
    o_tx_valid && i_tx_ready |=> !o_tx_valid)
    else $error("tx valid held after accept");
  wr_rx_a: assert property (
    o_wr_valid |-> $past(i_rx_valid))
    else $error("write byte without rx char");
  rd_load_a: assert property (
    o_rd_take |-> o_tx_valid && o_tx_data == $past(i_rd_data))
    else $error("read byte not loaded");
  end_one_a: assert property (
    !(o_done && o_abort))
    else $error("done and abort together");
  hdr_ack_a: assert property (
    o_hdr_valid |-> ##[0:3] o_tx_valid && o_tx_data == C_ACK)
    else $error("header not acked");
  hdr_dir_a: assert property (
    o_hdr_valid |-> o_hdr_write || o_hdr_mtype <= MT_PLAIN_MAX)
    else $error("bit type read accepted");
  grant_peer_a: assert property (
    o_enq_grant |-> i_peer_mode)
    else $error("grant outside peer mode");
  cover property (o_hdr_valid && o_hdr_write);
  cover property (o_rd_take);
  cover property (o_done);
endmodule
bind psb_framer psb_framer_asserts u_psb_framer_asserts (
  .i_sys_clk, .i_resetn, .i_peer_mode, .i_rx_valid, .i_tx_ready,
  .i_rd_data, .o_tx_valid, .o_tx_data, .o_rd_take, .o_wr_valid,
  .o_hdr_valid, .o_hdr_write, .o_hdr_mtype, .o_done, .o_abort,
  .o_enq_grant);
`default_nettype wire

// File: verification/psb_peer_model.sv
// Master station model on the character link
`timescale 1ns/10ps
`default_nettype none
module psb_peer_model (
  // Clock
  input  wire logic       i_sys_clk,
  // Link toward the framer
  input  wire logic       i_stall,
  output logic            o_tx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
  end
  assign o_tx_ready = ~i_stall;
  // Idle line shows the inverse, so stale data never matches
  task automatic send(input logic [7:0] c);
    @(negedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= c;
    @(negedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~c;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the serial block framer
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import psb_pkg::*;
  ;
  localparam logic [7:0] ADR = 8'h01 + C_ADDR_OFS;
  logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_peer_mode = 1'b0;
  logic        i_refuse = 1'b0, i_enq_req = 1'b0, i_rx_valid, i_tx_ready;
  logic [7:0]  i_station_id = 8'h01, i_rx_data, i_rd_data, o_tx_data;
  logic [1:0]  i_rate_sel = 2'h2;
  logic [31:0] i_quick_data = 32'h0;
  logic        o_tx_valid, o_rd_take, o_wr_valid, o_hdr_valid;
  logic        o_hdr_write, o_busy, o_done, o_abort, o_enq_grant;
  logic [7:0]  o_wr_data, exp_tx[$], exp_wr[$];
  logic [6:0]  o_hdr_mtype;
  logic [15:0] o_hdr_addr;
  logic        stall = 1'b0, slow = 1'b0;
  int          err_count = 0, n_checks = 0, cyc = 0, seed = 32'h6bd8;
  always #5 i_sys_clk = ~i_sys_clk;
  psb_framer #(.CYC_PER_MS_P(10)) u_psb_framer (.i_sys_clk, .i_resetn,
    .i_peer_mode, .i_station_id, .i_rate_sel, .i_refuse, .i_enq_req,
    .i_quick_data, .i_rx_valid, .i_rx_data, .o_tx_valid, .o_tx_data,
    .i_tx_ready, .i_rd_data, .o_rd_take, .o_wr_valid, .o_wr_data,
    .o_hdr_valid, .o_hdr_write, .o_hdr_mtype, .o_hdr_addr, .o_busy,
    .o_done, .o_abort, .o_enq_grant);
  psb_peer_model u_psb_peer_model (.i_sys_clk, .i_stall(stall),
    .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid),
    .o_rx_data(i_rx_data));
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  // Next read byte is presented only after the previous one is taken
  always @(negedge i_sys_clk) begin
    stall <= slow & $random(seed);
    if (o_rd_take) i_rd_data <= i_rd_data + 8'h01;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_tx_valid && i_tx_ready)
      chk("tx", o_tx_data, exp_tx.size() ? exp_tx.pop_front() : 32'h100);
    if (o_wr_valid)
      chk("wr", o_wr_data, exp_wr.size() ? exp_wr.pop_front() : 32'h100);
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic drain();
    for (int i = 0; i < 3000 && exp_tx.size() > 0; i++) @(negedge i_sys_clk);
    chk("tx left", exp_tx.size(), 0);
    repeat (4) @(negedge i_sys_clk);
  endtask
  task automatic wait_hi(input int k);
    logic f;
    f = 1'b0;
    // Look before waiting: end pulses last one cycle only
    for (int i = 0; i < 500 && !f; i++) begin
      f = (k == 0) ? o_done : (k == 1) ? !o_busy :
          (k == 2) ? o_enq_grant : o_abort;
      if (!f) @(negedge i_sys_clk);
    end
    chk("flag", f, 1'b1);
  endtask
  task automatic enq(input logic [7:0] k);
    u_psb_peer_model.send(k);
    u_psb_peer_model.send(ADR);
    u_psb_peer_model.send(C_ENQ);
  endtask
  task automatic hdr(input logic [7:0] d4, d5, nb, fl);
    logic [7:0] h[17];
    h = '{C_SOH, "0", "1", d4, d5, "0", "3", "D", "A", "0", "0", "0",
          nb, "0", "2", C_ETB, 8'h00};
    for (int i = 1; i < 15; i++) h[16] ^= h[i];
    h[16] ^= fl;
    for (int i = 0; i < 17; i++) u_psb_peer_model.send(h[i]);
  endtask
  task automatic wblk(input int n);
    logic [7:0] d, x;
    x = 8'h00;
    u_psb_peer_model.send(C_STX);
    repeat (n) begin
      d = $random(seed);
      x ^= d;
      exp_wr.push_back(d);
      u_psb_peer_model.send(d);
    end
    u_psb_peer_model.send(C_ETX);
    u_psb_peer_model.send(x);
  endtask
  initial begin
    i_rd_data = $random(seed);
    repeat (8) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    for (int r = 0; r < 2; r++) begin
      i_refuse = r[0];
      exp_tx = {C_NORMAL, ADR, r ? C_NAK : C_ACK};
      enq(C_NORMAL);
      drain();
      u_psb_peer_model.send(C_EOT);
      wait_hi(r ? 1 : 3);
    end
    i_refuse = 1'b0;
    slow = 1'b1;
    i_quick_data = $random(seed);
    exp_tx = {C_QUICK, ADR, i_quick_data[31:24], i_quick_data[23:16],
              i_quick_data[15:8], i_quick_data[7:0], i_quick_data[31:24]
              ^ i_quick_data[23:16] ^ i_quick_data[15:8]
              ^ i_quick_data[7:0], C_ACK};
    enq(C_QUICK);
    drain();
    slow = 1'b0;
    u_psb_peer_model.send(C_EOT);
    wait_hi(0);
    exp_tx = {C_NORMAL, ADR, C_ACK};
    enq(C_NORMAL);
    drain();
    exp_tx = {C_NAK};
    hdr("8", "1", "3", 8'h01);
    drain();
    exp_tx = {C_NAK};
    hdr("0", "D", "3", 8'h00);
    drain();
    exp_tx = {C_ACK};
    hdr("8", "1", "3", 8'h00);
    drain();
    chk("hdr", {o_hdr_write, o_hdr_mtype, o_hdr_addr}, 24'h8103da);
    exp_tx = {C_ACK};
    wblk(3);
    drain();
    chk("wr left", exp_wr.size(), 0);
    u_psb_peer_model.send(C_EOT);
    wait_hi(0);
    exp_tx = {C_NORMAL, ADR, C_ACK};
    enq(C_NORMAL);
    drain();
    exp_tx = {C_ACK, C_STX, i_rd_data, i_rd_data + 8'h01, C_ETX,
              i_rd_data ^ (i_rd_data + 8'h01)};
    hdr("0", "1", "2", 8'h00);
    drain();
    exp_tx = {C_EOT};
    u_psb_peer_model.send(C_ACK);
    drain();
    u_psb_peer_model.send(C_EOT);
    wait_hi(0);
    // Unanswered peer enquiry: reply wait, back-off, then a second ENQ
    i_peer_mode = 1'b1;
    exp_tx = {C_ENQ, C_ENQ};
    i_enq_req = 1'b1;
    @(negedge i_sys_clk);
    i_enq_req = 1'b0;
    for (int i = 0; i < 12000 && exp_tx.size() > 0; i++) @(negedge i_sys_clk);
    drain();
    u_psb_peer_model.send(C_ACK);
    wait_hi(2);
    end_sim();
  end
endmodule
`default_nettype wire
